// File: core/dsa_pkg.sv
// package: constants and types for the descriptor structure access evaluator
package dsa_pkg;
  localparam int unsigned AW = 24;
  localparam int unsigned LW = 24;
  localparam logic [AW-1:0] NIL = 24'hFFFFFF;
  // size word width in address units
  localparam logic [LW-1:0] SIZE_WORD = 24'h000018;
  localparam logic [AW-1:0] ZERO = 24'h000000;
  localparam logic [3:0] OP_W = 4'h4;

  typedef enum logic [4:0] {
    OP_STK_CONSTRUCT = 5'h00,
    OP_SV_ENTER = 5'h01,
    OP_SV_CONSTRUCT = 5'h02,
    OP_Q_ENTER = 5'h03,
    OP_Q_REMOVE = 5'h04,
    OP_Q_CONSTRUCT = 5'h05,
    OP_LL_ENTER = 5'h06,
    OP_LL_REMOVE = 5'h07,
    OP_LL_SEQUENCE = 5'h08,
    OP_LL_RESET = 5'h09,
    OP_PD_ENTER = 5'h0A,
    OP_PD_REMOVE = 5'h0B,
    OP_VQ_ENTER = 5'h0C,
    OP_VQ_REMOVE = 5'h0D
  } dsa_op_t;

  // fault bit positions in the interrupt-section pulse vector
  localparam int unsigned F_FULL = 0;
  localparam int unsigned F_EMPTY = 1;
  localparam int unsigned F_LIST = 2;
  localparam int unsigned NFLT = 3;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD = 3'b001,
    S_WR = 3'b010,
    S_DONE = 3'b011
  } dsa_state_t;
endpackage

// File: core/dsa_memport.sv
// single-word storage access sequencer shared by the evaluator
`timescale 1ns/1ps
module dsa_memport (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [23:0] addr,
  input wire logic [23:0] wdata,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [23:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [23:0] mem_rdata,
  output logic done,
  output logic [23:0] rdata
);
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic done;
    logic [23:0] rdata;
  } dsa_mp_t;
  dsa_mp_t s_r, s_nxt;

  // request held until storage acknowledges; done pulses one cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (s_r.req) begin
      if (mem_ack) begin
        s_nxt.req = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.rdata = mem_rdata;
      end
    end else if (start) begin
      s_nxt.req = 1'b1;
      s_nxt.we = wr;
      s_nxt.addr = addr;
      s_nxt.wdata = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_req = s_r.req;
  assign mem_we = s_r.we;
  assign mem_addr = s_r.addr;
  assign mem_wdata = s_r.wdata;
  assign done = s_r.done;
  assign rdata = s_r.rdata;
endmodule // dsa_memport

// File: core/dsa_eval.sv
// structure-expression evaluator: enter, remove and construct sequences
// Notes on behaviour
// - stack construct: reference at address minus length
// - stack-vector enter: reference, advance, write back
// - stack-vector construct: index from value stack, pop
// - queue enter: mod advance rear, full fault
// - queue remove/construct: empty fault, front reference
// - list enter: head insert or splice, current
// - list remove: nil head or current faults
// - list remove: unlink via fetched link word
// - list sequence: predecessor gets current, follow link
// - pushdown enter: size word, new length, advance
// - pushdown remove: step back, fetch old length
// - variable queue enter wrap: marker or full
// - variable queue enter: length word, advance rear
// - variable queue remove: advance, fetch, maybe wrap
// - faults pulse processor interrupt bits
// - size word has fixed width
`timescale 1ns/1ps
module dsa_eval (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [4:0] op,
  input wire logic [23:0] cont_addr,
  input wire logic [23:0] cont_len,
  input wire logic [23:0] vs_top,
  input wire logic [23:0] vs_depth,
  input wire logic [23:0] new_addr,
  input wire logic [23:0] new_len,
  input wire logic new_seg_ok,
  input wire logic [23:0] p_addr_in,
  input wire logic [23:0] p_len_in,
  input wire logic [23:0] p_rear_in,
  input wire logic [23:0] p_front_in,
  input wire logic [23:0] p_head_in,
  input wire logic [23:0] p_cur_in,
  input wire logic [23:0] p_pred_in,
  output logic [23:0] p_addr,
  output logic [23:0] p_len,
  output logic [23:0] p_rear,
  output logic [23:0] p_front,
  output logic [23:0] p_head,
  output logic [23:0] p_cur,
  output logic [23:0] p_pred,
  output logic params_valid,
  output logic vs_pop,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [23:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [23:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic [23:0] ref_addr,
  output logic [23:0] ref_len,
  output logic [2:0] fault
);
  // ***************************************************************
  // state record
  // ***************************************************************
  typedef struct packed {
    dsa_pkg::dsa_state_t st;
    dsa_pkg::dsa_op_t op;
    logic [1:0] step;
    logic [23:0] addr, len, rear, front, head, cur, pred;
    logic [23:0] t0, t1;
    logic pv, pop, done, bsy;
    logic [23:0] ra, rl;
    logic [2:0] flt;
    logic mstart, mwr;
    logic [23:0] ma, md;
  } dsa_ev_t;
  dsa_ev_t s_r, s_nxt;

  logic m_done;
  logic [23:0] m_rdata;

  dsa_memport u_mem (
    .clk(clk),
    .resetn(resetn),
    .start(s_r.mstart),
    .wr(s_r.mwr),
    .addr(s_r.ma),
    .wdata(s_r.md),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .done(m_done),
    .rdata(m_rdata)
  );

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // wrap-around add for circular queues; assumes pointer below length
  function automatic logic [23:0] modadd(input logic [23:0] a,
      input logic [23:0] b, input logic [23:0] m);
    logic [24:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (m != 24'h000000 && s >= {1'b0, m}) begin
      s = s - {1'b0, m};
    end
    modadd = s[23:0];
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.pv = 1'b0;
    s_nxt.pop = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.flt = 3'b000;
    s_nxt.mstart = 1'b0;
    case (s_r.st)
      dsa_pkg::S_IDLE: begin
        if (start) begin
          s_nxt.op = dsa_pkg::dsa_op_t'(op);
          s_nxt.addr = p_addr_in;
          s_nxt.len = p_len_in;
          s_nxt.rear = p_rear_in;
          s_nxt.front = p_front_in;
          s_nxt.head = p_head_in;
          s_nxt.cur = p_cur_in;
          s_nxt.pred = p_pred_in;
          s_nxt.step = 2'b00;
          s_nxt.st = dsa_pkg::S_RD;
        end
      end
      // decide: either finish, fault, or issue one storage access
      dsa_pkg::S_RD: begin
        s_nxt.st = dsa_pkg::S_DONE;
        s_nxt.ra = cont_addr + s_r.addr;
        s_nxt.rl = s_r.len;
        case (s_r.op)
          dsa_pkg::OP_STK_CONSTRUCT: s_nxt.ra = cont_addr + s_r.addr - s_r.len;
          dsa_pkg::OP_SV_ENTER: begin
            s_nxt.addr = s_r.addr + s_r.len;
            s_nxt.pv = 1'b1;
          end
          dsa_pkg::OP_SV_CONSTRUCT: begin
            s_nxt.ra = cont_addr + vs_top;
            s_nxt.pop = 1'b1;
          end
          dsa_pkg::OP_Q_ENTER: begin
            s_nxt.ra = cont_addr + s_r.rear;
            if (modadd(s_r.rear, s_r.len, cont_len) == s_r.front) begin
              s_nxt.flt[dsa_pkg::F_FULL] = 1'b1;
            end else begin
              s_nxt.rear = modadd(s_r.rear, s_r.len, cont_len);
              s_nxt.pv = 1'b1;
            end
          end
          dsa_pkg::OP_Q_REMOVE, dsa_pkg::OP_Q_CONSTRUCT: begin
            s_nxt.ra = cont_addr + s_r.front;
            if (s_r.front == s_r.rear) begin
              s_nxt.flt[dsa_pkg::F_EMPTY] = 1'b1;
            end else if (s_r.op == dsa_pkg::OP_Q_REMOVE) begin
              s_nxt.front = modadd(s_r.front, s_r.len, cont_len);
              s_nxt.pv = 1'b1;
            end
          end
          dsa_pkg::OP_LL_ENTER: begin
            s_nxt.t0 = new_addr - cont_addr - dsa_pkg::SIZE_WORD;
            if (!new_seg_ok || new_len != s_r.len ||
                new_addr - cont_addr + s_r.len > cont_len) begin
              s_nxt.flt[dsa_pkg::F_LIST] = 1'b1;
            end else if (s_r.pred == dsa_pkg::NIL) begin
              s_nxt.ma = new_addr - dsa_pkg::SIZE_WORD;
              s_nxt.md = s_r.head;
              s_nxt.mwr = 1'b1;
              s_nxt.mstart = 1'b1;
              s_nxt.st = dsa_pkg::S_WR;
            end else begin
              s_nxt.ma = cont_addr + s_r.pred;
              s_nxt.mwr = 1'b0;
              s_nxt.mstart = 1'b1;
              s_nxt.st = dsa_pkg::S_WR;
            end
          end
          dsa_pkg::OP_LL_REMOVE, dsa_pkg::OP_LL_SEQUENCE: begin
            if (s_r.head == dsa_pkg::NIL || s_r.cur == dsa_pkg::NIL) begin
              s_nxt.flt[dsa_pkg::F_LIST] = 1'b1;
            end else begin
              s_nxt.ma = cont_addr + s_r.cur;
              s_nxt.mwr = 1'b0;
              s_nxt.mstart = 1'b1;
              s_nxt.st = dsa_pkg::S_WR;
            end
          end
          dsa_pkg::OP_LL_RESET: begin
            s_nxt.pred = dsa_pkg::NIL;
            s_nxt.cur = s_r.head;
            s_nxt.pv = 1'b1;
          end
          dsa_pkg::OP_PD_ENTER: begin
            s_nxt.ma = cont_addr + s_r.addr;
            s_nxt.md = s_r.len;
            s_nxt.mwr = 1'b1;
            s_nxt.mstart = 1'b1;
            s_nxt.st = dsa_pkg::S_WR;
          end
          dsa_pkg::OP_PD_REMOVE: begin
            // step back past element and size word
            s_nxt.t0 = s_r.addr - s_r.len - dsa_pkg::SIZE_WORD;
            s_nxt.ra = cont_addr + s_r.addr - s_r.len;
            s_nxt.ma = cont_addr + s_r.addr - s_r.len - dsa_pkg::SIZE_WORD;
            s_nxt.mwr = 1'b0;
            s_nxt.mstart = 1'b1;
            s_nxt.st = dsa_pkg::S_WR;
          end
          dsa_pkg::OP_VQ_ENTER: begin
            s_nxt.ra = cont_addr + s_r.rear + dsa_pkg::SIZE_WORD;
            s_nxt.rl = vs_top;
            if (s_r.rear >= s_r.front && s_r.rear + dsa_pkg::SIZE_WORD +
                vs_top + dsa_pkg::SIZE_WORD > cont_len) begin
              if (vs_depth >= s_r.front) begin
                s_nxt.flt[dsa_pkg::F_FULL] = 1'b1;
              end else begin
                s_nxt.ma = cont_addr + s_r.rear;
                s_nxt.md = vs_top;
                s_nxt.mwr = 1'b1;
                s_nxt.mstart = 1'b1;
                s_nxt.rear = dsa_pkg::ZERO;
                s_nxt.ra = cont_addr + dsa_pkg::SIZE_WORD;
                s_nxt.st = dsa_pkg::S_WR;
              end
            end else if (s_r.rear + dsa_pkg::SIZE_WORD + vs_top >=
                         s_r.front && s_r.rear < s_r.front) begin
              s_nxt.flt[dsa_pkg::F_FULL] = 1'b1;
            end else begin
              s_nxt.ma = cont_addr + s_r.rear;
              s_nxt.md = vs_top;
              s_nxt.mwr = 1'b1;
              s_nxt.mstart = 1'b1;
              s_nxt.st = dsa_pkg::S_WR;
            end
          end
          dsa_pkg::OP_VQ_REMOVE: begin
            s_nxt.ra = cont_addr + s_r.front + dsa_pkg::SIZE_WORD;
            if (s_r.front == s_r.rear) begin
              s_nxt.flt[dsa_pkg::F_EMPTY] = 1'b1;
            end else begin
              s_nxt.front = s_r.front + dsa_pkg::SIZE_WORD + s_r.len;
              s_nxt.pv = (s_r.front + dsa_pkg::SIZE_WORD + s_r.len
                          == s_r.rear);
              if (s_r.front + dsa_pkg::SIZE_WORD + s_r.len != s_r.rear) begin
                s_nxt.ma = cont_addr + s_r.front + dsa_pkg::SIZE_WORD
                           + s_r.len;
                s_nxt.mwr = 1'b0;
                s_nxt.mstart = 1'b1;
                s_nxt.st = dsa_pkg::S_WR;
              end
            end
          end
          default: s_nxt.st = dsa_pkg::S_DONE;
        endcase
        if (s_nxt.flt != 3'b000) begin
          s_nxt.pv = 1'b0;
          s_nxt.pop = 1'b0;
        end
      end
      // wait on storage, then apply the access result
      dsa_pkg::S_WR: begin
        if (m_done) begin
          s_nxt.st = dsa_pkg::S_DONE;
          s_nxt.pv = 1'b1;
          case (s_r.op)
            dsa_pkg::OP_LL_ENTER: begin
              s_nxt.ra = new_addr;
              if (s_r.pred == dsa_pkg::NIL) begin
                s_nxt.head = s_r.t0;
                s_nxt.cur = s_r.t0;
              end else if (s_r.step == 2'b00) begin
                // new element takes pred link, pred points at it
                s_nxt.t1 = m_rdata;
                s_nxt.ma = new_addr - dsa_pkg::SIZE_WORD;
                s_nxt.md = m_rdata;
                s_nxt.mwr = 1'b1;
                s_nxt.mstart = 1'b1;
                s_nxt.step = 2'b01;
                s_nxt.pv = 1'b0;
                s_nxt.st = dsa_pkg::S_WR;
              end else if (s_r.step == 2'b01) begin
                s_nxt.ma = cont_addr + s_r.pred;
                s_nxt.md = s_r.t0;
                s_nxt.mwr = 1'b1;
                s_nxt.mstart = 1'b1;
                s_nxt.step = 2'b10;
                s_nxt.pv = 1'b0;
                s_nxt.st = dsa_pkg::S_WR;
              end else begin
                s_nxt.cur = s_r.t0;
              end
            end
            dsa_pkg::OP_LL_REMOVE: begin
              s_nxt.ra = cont_addr + s_r.cur + dsa_pkg::SIZE_WORD;
              if (s_r.step == 2'b00) begin
                s_nxt.t1 = m_rdata;
                if (s_r.cur == s_r.head) begin
                  s_nxt.head = m_rdata;
                  s_nxt.cur = m_rdata;
                end else begin
                  s_nxt.ma = cont_addr + s_r.pred;
                  s_nxt.md = m_rdata;
                  s_nxt.mwr = 1'b1;
                  s_nxt.mstart = 1'b1;
                  s_nxt.step = 2'b01;
                  s_nxt.pv = 1'b0;
                  s_nxt.st = dsa_pkg::S_WR;
                end
              end else begin
                s_nxt.cur = s_r.t1;
              end
            end
            dsa_pkg::OP_LL_SEQUENCE: begin
              s_nxt.pred = s_r.cur;
              s_nxt.cur = m_rdata;
            end
            dsa_pkg::OP_PD_ENTER: begin
              s_nxt.ra = cont_addr + s_r.addr + dsa_pkg::SIZE_WORD;
              s_nxt.rl = vs_top;
              s_nxt.addr = s_r.addr + dsa_pkg::SIZE_WORD;
              s_nxt.len = vs_top;
              s_nxt.pop = 1'b1;
            end
            dsa_pkg::OP_PD_REMOVE: begin
              s_nxt.addr = s_r.t0;
              s_nxt.len = m_rdata;
            end
            dsa_pkg::OP_VQ_ENTER: begin
              s_nxt.rear = s_r.rear + dsa_pkg::SIZE_WORD + vs_top;
              s_nxt.pop = 1'b1;
            end
            dsa_pkg::OP_VQ_REMOVE: begin
              // reset front when next element does not fit
              s_nxt.len = m_rdata;
              if (m_rdata > cont_len - s_r.front) begin
                s_nxt.front = dsa_pkg::ZERO;
              end
            end
            default: s_nxt.pv = 1'b0;
          endcase
        end
      end
      dsa_pkg::S_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = dsa_pkg::S_IDLE;
      end
      default: s_nxt.st = dsa_pkg::S_IDLE;
    endcase
    // busy kept as a flop so the output never glitches on state decode
    s_nxt.bsy = (s_nxt.st != dsa_pkg::S_IDLE);
  end

  // fault pulses registered to interrupt section
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign p_addr = s_r.addr;
  assign p_len = s_r.len;
  assign p_rear = s_r.rear;
  assign p_front = s_r.front;
  assign p_head = s_r.head;
  assign p_cur = s_r.cur;
  assign p_pred = s_r.pred;
  assign params_valid = s_r.pv;
  assign vs_pop = s_r.pop;
  assign busy = s_r.bsy;
  assign done = s_r.done;
  assign ref_addr = s_r.ra;
  assign ref_len = s_r.rl;
  assign fault = s_r.flt;
endmodule // dsa_eval

// File: tb/dsa_eval_props.sv
// checker: fault, sequencing and storage handshake relations
`timescale 1ns/1ps
module dsa_eval_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [4:0] op,
  input wire logic [23:0] cont_len,
  input wire logic [23:0] p_len_in,
  input wire logic [23:0] p_rear_in,
  input wire logic [23:0] p_front_in,
  input wire logic [23:0] p_head_in,
  input wire logic [23:0] p_cur_in,
  input wire logic [23:0] p_pred,
  input wire logic [23:0] p_cur,
  input wire logic params_valid,
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic busy,
  input wire logic done,
  input wire logic [2:0] fault
);
  // ****************
  // helper terms
  // ****************
  logic go;
  logic [23:0] nr;
  logic nil_ptr;
  // accepted request, advanced rear, and a nil list pointer
  assign go = start && !busy;
  assign nr = (p_rear_in + p_len_in) % cont_len;
  assign nil_ptr = (p_head_in == dsa_pkg::NIL) || (p_cur_in == dsa_pkg::NIL);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************
  // assertions
  // ****************
  // full queue fault
  chk_queue_full: assert property (
    go && op == dsa_pkg::OP_Q_ENTER && nr == p_front_in
    |-> ##2 fault[dsa_pkg::F_FULL])
    else $error("queue enter on a full queue gave no full fault");
  chk_queue_empty: assert property (
    go && (op == dsa_pkg::OP_Q_REMOVE || op == dsa_pkg::OP_Q_CONSTRUCT)
    && p_front_in == p_rear_in |-> ##2 fault[dsa_pkg::F_EMPTY])
    else $error("queue access on an empty queue gave no empty fault");
  chk_list_nil: assert property (
    go && (op == dsa_pkg::OP_LL_REMOVE || op == dsa_pkg::OP_LL_SEQUENCE)
    && nil_ptr |-> ##[1:2] fault[dsa_pkg::F_LIST])
    else $error("list step with a nil pointer gave no list fault");
  chk_list_reset: assert property (
    go && op == dsa_pkg::OP_LL_RESET |-> ##3 done
    && p_pred == dsa_pkg::NIL && p_cur == $past(p_head_in, 3))
    else $error("list reset left wrong predecessor or current");
  chk_fault_abandon: assert property (
    |fault |-> !params_valid ##1 (done && !params_valid))
    else $error("parameters written back around a fault");
  chk_fault_bit: assert property (
    |fault |-> busy && $onehot(fault))
    else $error("fault outside an operation or more than one bit");
  chk_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("storage request dropped or moved before answer");
  chk_done_bound: assert property (
    $rose(busy) |-> ##[1:60] done)
    else $error("operation did not finish");
endmodule // dsa_eval_props

bind dsa_eval dsa_eval_props u_props (.clk(clk), .resetn(resetn),
  .start(start), .op(op), .cont_len(cont_len), .p_len_in(p_len_in),
  .p_rear_in(p_rear_in), .p_front_in(p_front_in), .p_head_in(p_head_in),
  .p_cur_in(p_cur_in), .p_pred(p_pred), .p_cur(p_cur),
  .params_valid(params_valid), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .busy(busy), .done(done), .fault(fault));

// File: tb/dsa_mem_model.sv
// storage model answering single-word requests after a chosen delay
`timescale 1ns/1ps
module dsa_mem_model (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [23:0] mem_rdata
);
  logic [23:0] store [0:255];
  logic [1:0] cnt;
  // words start as their own low address byte, small valid offsets
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 24'h000000;
    cnt = 2'h0;
    for (int i = 0; i < 256; i++) begin
      store[i] = 24'(i);
    end
  end
  // idle data toggles so a stale word is never mistaken for an answer
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt == lat) begin
        mem_ack <= 1'b1;
        cnt <= 2'h0;
        if (mem_we) begin
          store[mem_addr[7:0]] <= mem_wdata;
        end else begin
          mem_rdata <= store[mem_addr[7:0]];
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // dsa_mem_model

// File: tb/descriptor_structure_access_tb.sv
// self-checking bench for the structure access evaluator
`timescale 1ns/1ps
module descriptor_structure_access_tb;
  typedef struct {
    logic [2:0] f;
    logic [1:0] side;
    int sel;
    logic [23:0] v;
  } dsa_exp_t;
  logic clk, resetn, start, new_seg_ok;
  logic [1:0] lat, s_acc;
  logic [4:0] op;
  logic [23:0] cont_addr, cont_len, vs_top, vs_depth, new_addr, new_len;
  logic [23:0] p_addr_in, p_len_in, p_rear_in, p_front_in;
  logic [23:0] p_head_in, p_cur_in, p_pred_in, nr;
  logic [23:0] p_addr, p_len, p_rear, p_front, p_head, p_cur, p_pred;
  logic [23:0] mem_addr, mem_wdata, mem_rdata, ref_addr, ref_len;
  logic params_valid, vs_pop, mem_req, mem_we, mem_ack, busy, done;
  logic [2:0] fault, f_acc;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int r;
  dsa_exp_t q[$];
  dsa_exp_t e;
  dsa_eval DUT (.*);
  dsa_mem_model u_mem (.*);
  // ****************
  // clock and shared tasks
  // ****************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hold above one keeps start high into busy, which must be ignored
  task automatic run(input dsa_pkg::dsa_op_t o, input logic [2:0] f,
      input logic [1:0] side, input int sel, input logic [23:0] v,
      input int hold);
    dsa_exp_t x;
    x = '{f, side, sel, v};
    @(negedge clk);
    op = o;
    start = 1'b1;
    q.push_back(x);
    repeat (hold) @(negedge clk);
    start = 1'b0;
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(negedge clk);
  endtask
  // ****************
  // monitor
  // ****************
  // side collects {vs_pop, params_valid} seen during the operation
  always @(posedge clk) begin
    if (start && !busy) begin
      f_acc = 3'h0;
      s_acc = 2'h0;
    end
    f_acc = f_acc | fault;
    s_acc = s_acc | {vs_pop, params_valid};
    if (done === 1'b1) begin
      if (q.size() == 0) begin
        check(24'h000001, 24'h000000);
      end else begin
        e = q.pop_front();
        check(24'(f_acc), 24'(e.f));
        check(24'(s_acc), 24'(e.side));
        case (e.sel)
          1: check(p_rear, e.v);
          2: check(p_front, e.v);
          3: check(p_pred, e.v);
          4: check(p_cur, e.v);
          5: check(ref_len, e.v);
          6: check(p_addr, e.v);
          7: check(p_len, e.v);
          8: check(ref_addr, e.v);
          default: ;
        endcase
      end
    end
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ****************
  // stimulus
  // ****************
  initial begin
    {resetn, start, new_seg_ok, lat, op} = 10'h000;
    {cont_addr, vs_top, vs_depth, new_addr, new_len} = 120'h0;
    {p_addr_in, p_len_in, p_rear_in, p_front_in} = 96'h0;
    {p_head_in, p_cur_in, p_pred_in} = 72'h0;
    cont_len = 24'h000040;
    r = $urandom(8895);
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    // queue wrap, full and empty on random pointers
    for (int i = 0; i < 16; i++) begin
      lat = 2'($urandom_range(3));
      p_len_in = 24'($urandom_range(15, 1));
      p_rear_in = 24'($urandom_range(63));
      p_front_in = 24'($urandom_range(63));
      nr = (p_rear_in + p_len_in) % cont_len;
      if (i % 4 == 0) p_front_in = nr;
      if (nr == p_front_in) run(dsa_pkg::OP_Q_ENTER, 3'h1, 2'h0, 0, 0, 1);
      else run(dsa_pkg::OP_Q_ENTER, 3'h0, 2'h1, 1, nr, 1);
      if (i % 4 == 1) p_front_in = p_rear_in;
      nr = (p_front_in + p_len_in) % cont_len;
      if (p_front_in == p_rear_in) begin
        run(dsa_pkg::OP_Q_REMOVE, 3'h2, 2'h0, 0, 0, 1);
        run(dsa_pkg::OP_Q_CONSTRUCT, 3'h2, 2'h0, 0, 0, 1);
      end else begin
        run(dsa_pkg::OP_Q_REMOVE, 3'h0, 2'h1, 2, nr, 1);
        run(dsa_pkg::OP_Q_CONSTRUCT, 3'h0, 2'h0, 5, p_len_in, 1 + i % 3);
      end
    end
    cont_addr = 24'h000100;
    cont_len = 24'h000100;
    p_addr_in = 24'h000030;
    p_len_in = 24'h000008;
    vs_top = 24'h000010;
    vs_depth = 24'h000010;
    run(dsa_pkg::OP_STK_CONSTRUCT, 3'h0, 2'h0, 8, 24'h000128, 1);
    run(dsa_pkg::OP_SV_ENTER, 3'h0, 2'h1, 6, 24'h000038, 1);
    run(dsa_pkg::OP_SV_CONSTRUCT, 3'h0, 2'h2, 8, 24'h000110, 1);
    run(dsa_pkg::OP_PD_ENTER, 3'h0, 2'h3, 7, 24'h000010, 1);
    run(dsa_pkg::OP_PD_REMOVE, 3'h0, 2'h1, 6, 24'h000010, 1);
    p_head_in = 24'h000020;
    p_cur_in = 24'h000040;
    run(dsa_pkg::OP_LL_RESET, 3'h0, 2'h1, 4, 24'h000020, 1);
    run(dsa_pkg::OP_LL_SEQUENCE, 3'h0, 2'h1, 3, 24'h000040, 1);
    for (int k = 0; k < 2; k++) begin
      p_head_in = k ? 24'h000020 : dsa_pkg::NIL;
      p_cur_in = k ? dsa_pkg::NIL : 24'h000040;
      run(dsa_pkg::OP_LL_REMOVE, 3'h4, 2'h0, 0, 0, 1);
      run(dsa_pkg::OP_LL_SEQUENCE, 3'h4, 2'h0, 0, 0, 1);
    end
    // head insert keeps nil predecessor, mismatch faults
    p_pred_in = dsa_pkg::NIL;
    new_addr = 24'h000140;
    new_len = 24'h000008;
    run(dsa_pkg::OP_LL_ENTER, 3'h4, 2'h0, 0, 0, 1);
    new_seg_ok = 1'b1;
    run(dsa_pkg::OP_LL_ENTER, 3'h0, 2'h1, 3, dsa_pkg::NIL, 1);
    new_len = 24'h000009;
    run(dsa_pkg::OP_LL_ENTER, 3'h4, 2'h0, 0, 0, 1);
    // unlink the new head, splice, unlink after predecessor
    p_head_in = 24'h000028;
    p_cur_in = 24'h000028;
    run(dsa_pkg::OP_LL_REMOVE, 3'h0, 2'h1, 4, 24'h000020, 1);
    p_pred_in = 24'h000028;
    new_addr = 24'h000160;
    new_len = 24'h000008;
    run(dsa_pkg::OP_LL_ENTER, 3'h0, 2'h1, 4, 24'h000048, 1);
    p_cur_in = 24'h000048;
    run(dsa_pkg::OP_LL_REMOVE, 3'h0, 2'h1, 4, 24'h000020, 1);
    p_rear_in = 24'h000000;
    p_front_in = 24'h000020;
    run(dsa_pkg::OP_VQ_ENTER, 3'h1, 2'h0, 0, 0, 1);
    p_rear_in = 24'h0000F0;
    p_front_in = 24'h000010;
    vs_top = 24'h000020;
    vs_depth = 24'h000020;
    run(dsa_pkg::OP_VQ_ENTER, 3'h1, 2'h0, 0, 0, 1);
    p_front_in = p_rear_in;
    run(dsa_pkg::OP_VQ_REMOVE, 3'h2, 2'h0, 0, 0, 1);
    // enter, wrap with marker, remove with and without reset
    p_rear_in = 24'h000010;
    p_front_in = 24'h000080;
    run(dsa_pkg::OP_VQ_ENTER, 3'h0, 2'h3, 1, 24'h000048, 1);
    p_rear_in = 24'h0000F0;
    p_front_in = 24'h000030;
    run(dsa_pkg::OP_VQ_ENTER, 3'h0, 2'h3, 1, 24'h000038, 1);
    p_rear_in = 24'h000080;
    p_front_in = 24'h000010;
    run(dsa_pkg::OP_VQ_REMOVE, 3'h0, 2'h1, 2, 24'h000030, 1);
    p_front_in = 24'h0000C0;
    run(dsa_pkg::OP_VQ_REMOVE, 3'h0, 2'h1, 2, 24'h000000, 1);
    repeat (4) @(negedge clk);
    check(24'(q.size()), 24'h000000);
    end_of_test();
  end
endmodule // descriptor_structure_access_tb
